// ==== sid_properties.sv ====
// assertions on the decoder outputs
`timescale 1ns/1ps
module sid_checker (
   input logic clk_sys,
   input logic rst_n,
   input logic tapReset,
   input logic [7:0] instr,
   input logic [1:0] drSelect,
   input logic [1:0] modeCode,
   input logic [1:0] captureKind,
   input logic outFloat,
   input logic runActive,
   input logic toggleStep,
   input logic holdInputs
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   property p_trst;
      tapReset [*8] |-> instr == 8'h81 && drSelect == 2'h2;
   endproperty
   a_trst: assert property (p_trst) else $error("no ident");
   property p_byp;
      drSelect == 2'h0 |-> captureKind == 2'h0;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass cap");
   property p_float;
      outFloat == (modeCode == 2'h2);
   endproperty
   a_float: assert property (p_float) else $error("float");
   // decode is registered in the same cycle as the opcode
   property p_par;
      (^instr) [*3] |-> drSelect == 2'h0 && modeCode == 2'h0;
   endproperty
   a_par: assert property (p_par) else $error("parity");
   property p_run;
      runActive |-> modeCode == 2'h1 && drSelect == 2'h0;
   endproperty
   a_run: assert property (p_run) else $error("run");
   property p_tog;
      toggleStep |-> holdInputs ##1 !toggleStep;
   endproperty
   a_tog: assert property (p_tog) else $error("toggle");
   property p_hold;
      holdInputs |-> modeCode == 2'h1 && captureKind == 2'h0;
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_ctl;
      drSelect == 2'h3 |-> captureKind == 2'h2;
   endproperty
   a_ctl: assert property (p_ctl) else $error("ctl cap");
   cover property (toggleStep);
   cover property (runActive);
   cover property (outFloat);
endmodule // sid_checker
bind sid_scan_instruction_decoder sid_checker chk (.clk_sys, .rst_n,
   .tapReset, .instr, .drSelect, .modeCode, .captureKind, .outFloat,
   .runActive, .toggleStep, .holdInputs);

// ==== sid_regs.vh ====
// constants for the scan instruction decoder
// Notes on behaviour
// - eight-bit opcodes, bit seven gives even parity
// - extest/intest: boundary chain selected, test mode
// - unlisted or unsupported opcodes act as bypass
// - bypass: one-bit register captures zero, normal mode
// - sample: boundary chain captures pins, normal mode
// - high-z: bypass selected, modified test mode
// - clamp: bypass selected, cells drive, test mode
// - run-test: bypass selected, test mode, operation in idle
// - five run-test operations selectable by control register
// - boundary read: chain unchanged, normal or test
// - self-check: cells capture inverse, normal mode
// - toggle outputs: bypass, outputs toggle in idle
// - toggle outputs: inputs held, not captured, test
// - control scan: control register held, normal or test
// - control register 21 bits, kept at capture
// - identification register 32 bits, shifted towards output
// - operation chosen by control register bits two to zero
`ifndef SID_REGS_VH
`define SID_REGS_VH
`define SID_IR_W 8
`define SID_CTL_W 21
`define SID_ID_W 32
`define SID_OP_EXTEST 8'h00
`define SID_OP_IDENT 8'h81
`define SID_OP_SAMPLE 8'h82
`define SID_OP_INTEST 8'h03
`define SID_OP_HIGHZ 8'h06
`define SID_OP_CLAMP 8'h87
`define SID_OP_RUNOP 8'h09
`define SID_OP_READ_BOUNDARY_NORMAL 8'h0A
`define SID_OP_READ_BOUNDARY_TESTMODE 8'h8B
`define SID_OP_CELLCHK 8'h0C
`define SID_OP_TOGGLE 8'h8D
`define SID_OP_CTLN 8'h8E
`define SID_OP_CTLT 8'h0F
// data register select codes
`define SID_DR_BYPASS 2'h0
`define SID_DR_BOUND 2'h1
`define SID_DR_IDENT 2'h2
`define SID_DR_CTL 2'h3
// mode codes
`define SID_MODE_NORMAL 2'h0
`define SID_MODE_TEST 2'h1
`define SID_MODE_MODTEST 2'h2
// capture behaviour of the selected register
`define SID_CAP_ZERO 2'h0
`define SID_CAP_PINS 2'h1
`define SID_CAP_HOLD 2'h2
`define SID_CAP_INVERT 2'h3
// run-test operation codes, bits 2..0
`define SID_RUN_TOGGLE 3'h0
`define SID_RUN_PATTERN 3'h1
`define SID_RUN_SIG 3'h2
`define SID_RUN_SIGPAT 3'h3
`define SID_RUN_SIGCNT 3'h7
`define SID_ID_RESET 32'h00000001
`endif

// ==== sid_scan_instruction_decoder.v ====
// instruction decoder with identification and control registers
`timescale 1ns/1ps
`include "sid_regs.vh"
module sid_scan_instruction_decoder #(
   parameter [31:0] ID_VALUE = 32'h12345671 // arbitrary value
) (
   clk_sys,
   rst_n,
   tck,
   tdi,
   tapReset,
   captureIr,
   shiftIr,
   updateIr,
   captureDr,
   shiftDr,
   runIdle,
   bndTdo,
   irShiftOut,
   instr,
   drSelect,
   modeCode,
   captureKind,
   testMode,
   outFloat,
   runActive,
   runOp,
   maskBits,
   toggleStep,
   holdInputs,
   bypassTdo,
   identTdo,
   ctlTdo,
   scanTdo
);
   input wire clk_sys;
   input wire rst_n;
   input wire tck;
   input wire tdi;
   input wire tapReset;
   input wire captureIr;
   input wire shiftIr;
   input wire updateIr;
   input wire captureDr;
   input wire shiftDr;
   input wire runIdle;
   input wire bndTdo;
   output reg irShiftOut;
   output reg [7:0] instr;
   output reg [1:0] drSelect;
   output reg [1:0] modeCode;
   output reg [1:0] captureKind;
   output reg testMode;
   output reg outFloat;
   output reg runActive;
   output reg [2:0] runOp;
   output reg [17:0] maskBits;
   output reg toggleStep;
   output reg holdInputs;
   output reg bypassTdo;
   output reg identTdo;
   output reg ctlTdo;
   output reg scanTdo;

   // decoded fields of one opcode: {dr, mode, capture}
   function [5:0] decode;
      input [7:0] op;
      begin
         case (op)
            `SID_OP_EXTEST,
            `SID_OP_INTEST:
               decode = {`SID_DR_BOUND, `SID_MODE_TEST, `SID_CAP_PINS};
            `SID_OP_IDENT:
               decode = {`SID_DR_IDENT, `SID_MODE_NORMAL, `SID_CAP_PINS};
            `SID_OP_SAMPLE:
               decode = {`SID_DR_BOUND, `SID_MODE_NORMAL, `SID_CAP_PINS};
            `SID_OP_HIGHZ:
               decode = {`SID_DR_BYPASS, `SID_MODE_MODTEST, `SID_CAP_ZERO};
            `SID_OP_CLAMP:
               decode = {`SID_DR_BYPASS, `SID_MODE_TEST, `SID_CAP_ZERO};
            `SID_OP_RUNOP:
               decode = {`SID_DR_BYPASS, `SID_MODE_TEST, `SID_CAP_ZERO};
            `SID_OP_READ_BOUNDARY_NORMAL:
               decode = {`SID_DR_BOUND, `SID_MODE_NORMAL, `SID_CAP_HOLD};
            `SID_OP_READ_BOUNDARY_TESTMODE:
               decode = {`SID_DR_BOUND, `SID_MODE_TEST, `SID_CAP_HOLD};
            `SID_OP_CELLCHK:
               decode = {`SID_DR_BOUND, `SID_MODE_NORMAL, `SID_CAP_INVERT};
            `SID_OP_TOGGLE:
               decode = {`SID_DR_BYPASS, `SID_MODE_TEST, `SID_CAP_ZERO};
            `SID_OP_CTLN:
               decode = {`SID_DR_CTL, `SID_MODE_NORMAL, `SID_CAP_HOLD};
            `SID_OP_CTLT:
               decode = {`SID_DR_CTL, `SID_MODE_TEST, `SID_CAP_HOLD};
            // 84, 05, 88 and everything else fall back to bypass
            default:
               decode = {`SID_DR_BYPASS, `SID_MODE_NORMAL, `SID_CAP_ZERO};
         endcase
      end
   endfunction

   // link signals all come from another clock domain
   wire [9:0] syncOut;
   sid_sync #(.W(10)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .din({tck, tdi, tapReset, captureIr, shiftIr, updateIr,
            captureDr, shiftDr, runIdle, bndTdo}),
      .dout(syncOut)
   );
   wire tckS = syncOut[9];
   wire tdiS = syncOut[8];
   wire resetS = syncOut[7];
   wire capIrS = syncOut[6];
   wire shIrS = syncOut[5];
   wire updIrS = syncOut[4];
   wire capDrS = syncOut[3];
   wire shDrS = syncOut[2];
   wire idleS = syncOut[1];
   wire bndS = syncOut[0];

   reg tckDly_ff;
   always @(posedge clk_sys) begin
      if (!rst_n)
         tckDly_ff <= 1'b0;
      else
         tckDly_ff <= tckS;
   end
   wire tckRise = tckS & ~tckDly_ff;
   wire tckFall = ~tckS & tckDly_ff;

   // instruction shift stage; capture loads the standard 01 pattern
   reg [7:0] irShift_ff;
   reg [7:0] instr_ff;
   always @(posedge clk_sys) begin
      if (!rst_n || resetS) begin
         irShift_ff <= `SID_OP_IDENT;
         instr_ff <= `SID_OP_IDENT;
      end else if (tckRise) begin
         if (capIrS)
            irShift_ff <= 8'h01;
         else if (shIrS)
            irShift_ff <= {tdiS, irShift_ff[7:1]};
      end else if (tckFall && updIrS) begin
         // odd-parity codes are not valid and fall to bypass anyway
         instr_ff <= irShift_ff;
      end
   end

   wire [5:0] dec = decode(instr_ff);
   wire [1:0] selDr = dec[5:4];
   wire [1:0] selMode = dec[3:2];

   // bypass bit
   reg bypass_ff;
   always @(posedge clk_sys) begin
      if (!rst_n)
         bypass_ff <= 1'b0;
      else if (tckRise && capDrS && selDr == `SID_DR_BYPASS)
         bypass_ff <= 1'b0;
      else if (tckRise && shDrS && selDr == `SID_DR_BYPASS)
         bypass_ff <= tdiS;
   end

   // identification register
   wire idTdoW;
   sid_shift_reg #(.W(`SID_ID_W)) u_ident (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .capture(tckRise && capDrS && selDr == `SID_DR_IDENT),
      .shift(tckRise && shDrS && selDr == `SID_DR_IDENT),
      .capVal(ID_VALUE),
      .tdiBit(tdiS),
      .value(),
      .tdoBit(idTdoW)
   );

   // run-op control register: capture reloads its own value
   reg [`SID_CTL_W-1:0] ctl_ff;
   always @(posedge clk_sys) begin
      if (!rst_n || resetS)
         ctl_ff <= {`SID_CTL_W{1'b0}};
      else if (tckRise && shDrS && selDr == `SID_DR_CTL)
         ctl_ff <= {tdiS, ctl_ff[`SID_CTL_W-1:1]};
   end

   // run-test activity only in idle; relies on prior load of ctl
   wire isRun = (instr_ff == `SID_OP_RUNOP);
   wire isTog = (instr_ff == `SID_OP_TOGGLE);

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         irShiftOut <= 1'b1;
         instr <= `SID_OP_IDENT;
         drSelect <= `SID_DR_IDENT;
         modeCode <= `SID_MODE_NORMAL;
         captureKind <= `SID_CAP_PINS;
         testMode <= 1'b0;
         outFloat <= 1'b0;
         runActive <= 1'b0;
         runOp <= `SID_RUN_TOGGLE;
         maskBits <= 18'h00000;
         toggleStep <= 1'b0;
         holdInputs <= 1'b0;
         bypassTdo <= 1'b0;
         identTdo <= 1'b0;
         ctlTdo <= 1'b0;
         scanTdo <= 1'b0;
      end else begin
         irShiftOut <= irShift_ff[0];
         instr <= instr_ff;
         drSelect <= selDr;
         modeCode <= selMode;
         captureKind <= dec[1:0];
         testMode <= (selMode == `SID_MODE_TEST);
         outFloat <= (selMode == `SID_MODE_MODTEST);
         runActive <= isRun && idleS;
         runOp <= ctl_ff[2:0];
         maskBits <= ctl_ff[20:3];
         // toggle pulse per tck rise in idle; cells invert, then
         // update shadows on the following fall
         toggleStep <= isTog && idleS && tckRise;
         holdInputs <= isTog;
         bypassTdo <= bypass_ff;
         identTdo <= idTdoW;
         ctlTdo <= ctl_ff[0];
         case (selDr)
            `SID_DR_BOUND: scanTdo <= bndS;
            `SID_DR_IDENT: scanTdo <= idTdoW;
            `SID_DR_CTL: scanTdo <= ctl_ff[0];
            default: scanTdo <= bypass_ff;
         endcase
      end
   end
endmodule // sid_scan_instruction_decoder

// ==== sid_scan_instruction_decoder_tb.sv ====
// self-checking bench for the scan instruction decoder
`timescale 1ns/1ps
module sid_scan_instruction_decoder_tb;
   localparam logic [31:0] ID = 32'h12345671; // arbitrary value
   logic clk_sys, rst_n;
   wire tck, tdi, tapReset, captureIr, shiftIr, updateIr, captureDr;
   wire shiftDr, runIdle, bndTdo, irShiftOut, testMode, outFloat;
   wire runActive, toggleStep, holdInputs, bypassTdo, identTdo, ctlTdo;
   wire scanTdo;
   wire [7:0] instr;
   wire [1:0] drSelect, modeCode, captureKind;
   wire [2:0] runOp;
   wire [17:0] maskBits;
   int fail_count = 0, total_checks = 0, cyc = 0, steps = 0;
   logic [31:0] got;
   // opcode, register, mode * 4 + capture
   logic [15:0] rows [19] = '{16'h0015, 16'h8120, 16'h8211, 16'h0315,
      16'h8400, 16'h0500, 16'h0608, 16'h8704, 16'h8800, 16'h0904,
      16'h0A12, 16'h8B16, 16'h0C13, 16'h8D04, 16'h8E32, 16'h0F36,
      16'hFF00, 16'h0100, 16'h7E00};
   logic [2:0] ops [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   sid_tap_model tap (.clk_sys, .scanTdo, .tck, .tdi, .tapReset,
      .captureIr, .shiftIr, .updateIr, .captureDr, .shiftDr, .runIdle,
      .bndTdo);
   sid_scan_instruction_decoder #(.ID_VALUE(ID)) dut (.clk_sys, .rst_n,
      .tck, .tdi, .tapReset, .captureIr, .shiftIr, .updateIr, .captureDr,
      .shiftDr, .runIdle, .bndTdo, .irShiftOut, .instr, .drSelect,
      .modeCode, .captureKind, .testMode, .outFloat, .runActive, .runOp,
      .maskBits, .toggleStep, .holdInputs, .bypassTdo, .identTdo,
      .ctlTdo, .scanTdo);
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (toggleStep === 1'b1)
         steps++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      repeat (20) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk("reset instr", 8'h81, instr);
      chk("reset dr", 2'h2, drSelect);
      $display("test reset done");
      foreach (rows[k]) begin
         tap.load_ir(rows[k][15:8]);
         chk("instr", rows[k][15:8], instr);
         chk("irout", rows[k][8], irShiftOut);
         chk("dr", rows[k][5:4], drSelect);
         chk("mode", rows[k][3:2], modeCode);
         chk("test", rows[k][3:2] == 2'h1, testMode);
         if (rows[k][5:4] != 2'h2)
            chk("cap", rows[k][1:0], captureKind);
         chk("float", rows[k][3:2] == 2'h2, outFloat);
      end
      $display("test decode done");
      tap.load_ir(8'h84);
      tap.scan_dr(2, 32'h3, got);
      tap.scan_dr(2, 32'h3, got);
      chk("bypass out", 32'h2, got);
      chk("bypass bit", 1'b1, bypassTdo);
      tap.load_ir(8'h81);
      tap.scan_dr(32, 32'h1, got);
      chk("ident", ID, got);
      chk("ident bit", 1'b1, identTdo);
      $display("test scan done");
      foreach (ops[k]) begin
         tap.load_ir(8'h8E);
         tap.scan_dr(21, {11'h0, 18'h2AB5, ops[k]}, got);
         chk("ctl bit", ops[k][0], ctlTdo);
         tap.load_ir(8'h09);
         tap.runIdle = 1'b1;
         repeat (6) @(posedge clk_sys);
         #1 chk("run", 1'b1, runActive);
         chk("runOp", ops[k], runOp);
         chk("mask", 18'h2AB5, maskBits);
         tap.runIdle = 1'b0;
      end
      tap.load_ir(8'h0F);
      tap.scan_dr(21, 32'h0, got);
      chk("ctl hold", {11'h0, 18'h2AB5, 3'h7}, got);
      $display("test control done");
      tap.load_ir(8'h8D);
      tap.runIdle = 1'b1;
      steps = 0;
      repeat (3) tap.pulse();
      repeat (6) @(posedge clk_sys);
      #1 chk("steps", 3, steps);
      chk("hold", 1'b1, holdInputs);
      tap.runIdle = 1'b0;
      $display("test toggle done");
      tap.tapReset = 1'b1;
      repeat (12) @(posedge clk_sys);
      #1 chk("tap reset", 8'h81, instr);
      tap.tapReset = 1'b0;
      $display("test tap reset done");
      final_report();
   end
endmodule // sid_scan_instruction_decoder_tb

// ==== sid_shift_reg.v ====
// data shift register with capture, shift and parallel value
`timescale 1ns/1ps
module sid_shift_reg #(
   parameter W = 32
) (
   clk_sys,
   rst_n,
   capture,
   shift,
   capVal,
   tdiBit,
   value,
   tdoBit
);
   input wire clk_sys;
   input wire rst_n;
   input wire capture;
   input wire shift;
   input wire [W-1:0] capVal;
   input wire tdiBit;
   output reg [W-1:0] value;
   output wire tdoBit;
   // shifts from the input end at the top bit toward bit 0
   always @(posedge clk_sys) begin
      if (!rst_n)
         value <= {W{1'b0}};
      else if (capture)
         value <= capVal;
      else if (shift)
         value <= {tdiBit, value[W-1:1]};
   end
   assign tdoBit = value[0];
endmodule // sid_shift_reg

// ==== sid_sync.v ====
// two-flop synchroniser for link inputs
`timescale 1ns/1ps
module sid_sync #(
   parameter W = 1
) (
   clk_sys,
   rst_n,
   din,
   dout
);
   input wire clk_sys;
   input wire rst_n;
   input wire [W-1:0] din;
   output reg [W-1:0] dout;
   reg [W-1:0] meta_ff;
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_ff <= {W{1'b0}};
         dout <= {W{1'b0}};
      end else begin
         meta_ff <= din;
         dout <= meta_ff;
      end
   end
endmodule // sid_sync

// ==== sid_tap_model.sv ====
// tap controller model driving the link side
`timescale 1ns/1ps
module sid_tap_model (
   input logic clk_sys,
   input logic scanTdo,
   output logic tck,
   output logic tdi,
   output logic tapReset,
   output logic captureIr,
   output logic shiftIr,
   output logic updateIr,
   output logic captureDr,
   output logic shiftDr,
   output logic runIdle,
   output logic bndTdo
);
   initial begin
      {tck, tdi, tapReset, captureIr, shiftIr} = 5'h0;
      {updateIr, captureDr, shiftDr, runIdle, bndTdo} = 5'h0;
   end
   task automatic half(input logic v);
      repeat (4) @(posedge clk_sys);
      #1 tck = v;
      bndTdo = ~bndTdo;
   endtask
   task automatic pulse();
      half(1'b1);
      half(1'b0);
   endtask
   // lsb first; tdi inverted once released so stale bits never match
   task automatic load_ir(input logic [7:0] op);
      captureIr = 1'b1;
      pulse();
      {captureIr, shiftIr} = 2'b01;
      for (int i = 0; i < 8; i++) begin
         tdi = op[i];
         pulse();
      end
      {shiftIr, updateIr, tdi} = {2'b01, ~tdi};
      pulse();
      repeat (10) @(posedge clk_sys);
      #1 updateIr = 1'b0;
   endtask
   task automatic scan_dr(input int n, input logic [31:0] din,
         output logic [31:0] dout);
      dout = 32'h0;
      captureDr = 1'b1;
      pulse();
      {captureDr, shiftDr} = 2'b01;
      for (int i = 0; i < n; i++) begin
         tdi = din[i];
         repeat (3) @(posedge clk_sys);
         #2 dout[i] = scanTdo;
         pulse();
      end
      {shiftDr, tdi} = {1'b0, ~tdi};
   endtask
endmodule // sid_tap_model
